//--- verilog/spcd_top.sv
// serial clock divider, data port, receive fifo and slave lane
// assumes sys_clk at 25 mhz and a link clock pin from an outside master
`timescale 1ns/1ps

// ----------------------------------------
// receive fifo
// ----------------------------------------
module spcd_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // clock
   input wire logic clk,
   input wire logic rst,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0] cnt_q, cnt_d;
   logic push, pop;
   always_comb begin
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      wr_d = push ? AW'(wr_q + 1'b1) : wr_q;
      rd_d = pop ? AW'(rd_q + 1'b1) : rd_q;
      cnt_d = (AW+1)'(cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
      in_ready = (cnt_q != (AW+1)'(DEPTH));
      out_valid = (cnt_q != '0);
      out_data = mem_q[rd_q];
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
      end
   end
   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end
endmodule : spcd_fifo

// ----------------------------------------
// controller top
// ----------------------------------------
module spcd_top (
   // system clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // special-register port
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   // control and status
   input wire logic spi_en,
   input wire logic master_en,
   input wire logic clock_polarity_select,
   input wire logic clock_phase_select,
   input wire logic done_clear,
   output logic transmit_buffer_empty,
   output logic transfer_done_flag,
   // serial clock pin, link clock when slave
   input wire logic lk_sck,
   output logic sck_o,
   output logic sck_oe_n,
   // data pins and slave select
   input wire logic mosi_i,
   output logic mosi_o,
   output logic mosi_oe_n,
   input wire logic miso_i,
   output logic miso_o,
   output logic miso_oe_n,
   input wire logic nss_n_i
);
   import spcd_pkg::*;
   // ----------------------------------------
   // state
   // ----------------------------------------
   spcd_state_t st_q, st_d;
   logic [7:0] div_q, div_d, cnt_q, cnt_d, txb_q, txb_d, tsr_q, tsr_d, rsr_q, rsr_d;
   logic [7:0] rdat_q, rdat_d;
   logic [2:0] bit_q, bit_d;
   logic half_q, half_d, txe_q, txe_d, done_q, done_d;
   logic sck_q, sck_d, mosi_q, mosi_d, soe_q, soe_d, moe_q, moe_d, ooe_q, ooe_d;
   logic miso_s1_q, miso_s2_q, nss_s1_q, nss_s2_q, nss_s3_q;
   logic tg_s1_q, tg_s2_q, tg_s3_q;
   logic wr_data, rd_data, load, bit_end, slv_done, slv_start;
   logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
   logic [7:0] f_in_data, f_out_data;
   // link domain
   logic lk_clk_eff, edge_sel;
   logic [2:0] lk_cnt_q, lk_ocnt_q;
   logic [7:0] lk_sr_q, lk_hold_q;
   logic lk_tg_q;

   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      miso_s1_q <= miso_i;
      miso_s2_q <= miso_s1_q;
      nss_s1_q <= nss_n_i;
      nss_s2_q <= nss_s1_q;
      nss_s3_q <= nss_s2_q;
      tg_s1_q <= lk_tg_q;
      tg_s2_q <= tg_s1_q;
      tg_s3_q <= tg_s2_q;
   end

   // ----------------------------------------
   // slave lane on the link clock
   // ----------------------------------------
   // sample edge is the rising edge of the effective clock
   assign edge_sel = clock_polarity_select ^ clock_phase_select;
   assign lk_clk_eff = lk_sck ^ edge_sel;
   always_ff @(posedge lk_clk_eff or posedge nss_n_i) begin
      if (nss_n_i) begin
         lk_cnt_q <= 3'h0;
      end else begin
         lk_cnt_q <= lk_cnt_q + 3'h1;
      end
   end
   always_ff @(posedge lk_clk_eff) begin
      lk_sr_q <= {lk_sr_q[6:0], mosi_i};
      if (lk_cnt_q == SPCD_LAST_BIT) begin
         lk_hold_q <= {lk_sr_q[6:0], mosi_i};
      end
   end
   // toggle needs a known start or the done clear is blocked
   always_ff @(posedge lk_clk_eff or posedge sys_rst) begin
      if (sys_rst) begin
         lk_tg_q <= 1'b0;
      end else if (lk_cnt_q == SPCD_LAST_BIT) begin
         lk_tg_q <= ~lk_tg_q;
      end
   end
   always_ff @(negedge lk_clk_eff or posedge nss_n_i) begin
      if (nss_n_i) begin
         lk_ocnt_q <= 3'h0;
      end else begin
         lk_ocnt_q <= lk_cnt_q;
      end
   end
   // transmit bit is read live from txb_q; slave start sets the empty flag, so a data write mid-frame changes it
   assign miso_o = txb_q[3'h7 - lk_ocnt_q];

   // ----------------------------------------
   // receive fifo
   // ----------------------------------------
   spcd_fifo #(.WIDTH(SPCD_BYTE_W), .DEPTH(SPCD_FIFO_DEPTH)) u_rx_fifo (
      .clk(sys_clk),
      .rst(sys_rst),
      .in_valid(f_in_valid),
      .in_ready(f_in_ready),
      .in_data(f_in_data),
      .out_valid(f_out_valid),
      .out_ready(f_out_ready),
      .out_data(f_out_data)
   );

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      wr_data = sfr_wr && (sfr_addr == SPCD_ADDR_DATA);
      rd_data = sfr_rd && (sfr_addr == SPCD_ADDR_DATA);
      slv_done = tg_s2_q ^ tg_s3_q;
      slv_start = nss_s3_q && !nss_s2_q && spi_en && !master_en;
      bit_end = (st_q == SPCD_RUN) && half_q && (cnt_q == div_q);
      div_d = div_q;
      txb_d = txb_q;
      txe_d = txe_q;
      done_d = done_q;
      st_d = st_q;
      cnt_d = cnt_q;
      half_d = half_q;
      bit_d = bit_q;
      tsr_d = tsr_q;
      rsr_d = rsr_q;
      load = 1'b0;
      f_in_valid = 1'b0;
      f_in_data = rsr_q;
      f_out_ready = rd_data;
      rdat_d = rdat_q;
      if (sfr_wr && sfr_addr == SPCD_ADDR_CLK_DIV) begin
         div_d = sfr_wdata;
      end
      // a write while the buffer is full is ignored
      if (wr_data && txe_q) begin
         txb_d = sfr_wdata;
         txe_d = 1'b0;
      end
      if (sfr_rd) begin
         rdat_d = 8'h00;
         if (sfr_addr == SPCD_ADDR_CLK_DIV) begin
            rdat_d = div_q;
         end else if (sfr_addr == SPCD_ADDR_DATA) begin
            rdat_d = f_out_data;
         end
      end
      unique case (st_q)
         SPCD_IDLE: begin
            // start waits for room in the receive fifo
            if (spi_en && master_en && !txe_q && f_in_ready) begin
               load = 1'b1;
            end
         end
         SPCD_RUN: begin
            if (cnt_q == div_q) begin
               cnt_d = 8'h00;
               half_d = ~half_q;
            end else begin
               cnt_d = cnt_q + 8'h01;
            end
            if (bit_end) begin
               rsr_d = {rsr_q[6:0], miso_s2_q};
               tsr_d = {tsr_q[6:0], 1'b0};
               bit_d = bit_q + 3'h1;
               if (bit_q == SPCD_LAST_BIT) begin
                  f_in_valid = 1'b1;
                  f_in_data = {rsr_q[6:0], miso_s2_q};
                  done_d = 1'b1;
                  st_d = SPCD_IDLE;
                  if (spi_en && master_en && !txe_d && f_in_ready) begin
                     load = 1'b1;
                  end
               end
            end
         end
      endcase
      if (load) begin
         st_d = SPCD_RUN;
         tsr_d = txb_d;
         txe_d = 1'b1;
         cnt_d = 8'h00;
         half_d = 1'b0;
         bit_d = 3'h0;
      end
      if (slv_start) begin
         txe_d = 1'b1;
      end
      if (slv_done) begin
         f_in_valid = 1'b1;
         f_in_data = lk_hold_q;
         done_d = 1'b1;
      end
      if (done_clear && !(bit_end && bit_q == SPCD_LAST_BIT) && !slv_done) begin
         done_d = 1'b0;
      end
      sck_d = clock_polarity_select ^ ((st_d == SPCD_RUN) && (half_d ^ clock_phase_select));
      mosi_d = tsr_d[7];
      soe_d = !(spi_en && master_en);
      moe_d = !(spi_en && master_en);
      ooe_d = !(spi_en && !master_en && !nss_s2_q);
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st_q <= SPCD_IDLE;
         div_q <= SPCD_CLK_DIV_RST;
         txb_q <= SPCD_DATA_RST;
         rdat_q <= SPCD_DATA_RST;
         tsr_q <= 8'h00;
         rsr_q <= 8'h00;
         cnt_q <= 8'h00;
         bit_q <= 3'h0;
         half_q <= 1'b0;
         txe_q <= 1'b1;
         done_q <= 1'b0;
         sck_q <= 1'b0;
         mosi_q <= 1'b0;
         soe_q <= 1'b1;
         moe_q <= 1'b1;
         ooe_q <= 1'b1;
      end else begin
         st_q <= st_d;
         div_q <= div_d;
         txb_q <= txb_d;
         rdat_q <= rdat_d;
         tsr_q <= tsr_d;
         rsr_q <= rsr_d;
         cnt_q <= cnt_d;
         bit_q <= bit_d;
         half_q <= half_d;
         txe_q <= txe_d;
         done_q <= done_d;
         sck_q <= sck_d;
         mosi_q <= mosi_d;
         soe_q <= soe_d;
         moe_q <= moe_d;
         ooe_q <= ooe_d;
      end
   end
   assign sfr_rdata = rdat_q;
   assign transmit_buffer_empty = txe_q;
   assign transfer_done_flag = done_q;
   assign sck_o = sck_q;
   assign sck_oe_n = soe_q;
   assign mosi_o = mosi_q;
   assign mosi_oe_n = moe_q;
   assign miso_oe_n = ooe_q;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   logic [8:0] hp_q;
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         hp_q <= 9'h001;
      end else if (load && st_q == SPCD_IDLE) begin
         hp_q <= 9'h000;
      end else if ($changed(sck_q)) begin
         hp_q <= 9'h001;
      end else begin
         hp_q <= hp_q + 9'h001;
      end
   end
   half_period_a: assert property ((st_q == SPCD_RUN) && $changed(sck_q) && $past(st_q) == SPCD_RUN
      |-> hp_q == {1'b0, div_q} + 9'h001) else $error("half period wrong");
   write_buf_a: assert property (wr_data && txe_q |=> txb_q == $past(sfr_wdata))
      else $error("data write lost");
   start_a: assert property (wr_data && txe_q && spi_en && master_en && st_q == SPCD_IDLE
      && f_in_ready ##1 spi_en && master_en |=> st_q == SPCD_RUN) else $error("no start");
   read_rx_a: assert property (rd_data |=> sfr_rdata == $past(f_out_data))
      else $error("read not receive buffer");
   idle_pol_a: assert property (st_q == SPCD_IDLE && $stable(clock_polarity_select) [*2]
      |-> sck_q == clock_polarity_select) else $error("idle polarity");
   txe_clr_a: assert property (wr_data && txe_q && !load && !slv_start |=> !txe_q)
      else $error("empty flag not cleared");
   txe_set_a: assert property (load |=> txe_q && st_q == SPCD_RUN)
      else $error("empty flag not set on load");
   done_set_a: assert property (bit_end && bit_q == SPCD_LAST_BIT |=> done_q)
      else $error("done not set");
   done_hold_a: assert property (done_q && !done_clear |=> done_q)
      else $error("done cleared by hardware");
   sample_a: assert property (bit_end |=> rsr_q[0] == $past(miso_s2_q))
      else $error("sample point wrong");
   master_cv: cover property (load ##[1:300] (bit_end && bit_q == SPCD_LAST_BIT));
   slave_cv: cover property (slv_start ##[1:300] slv_done);
   full_cv: cover property (!f_in_ready);
endmodule : spcd_top

//--- verilog/spcd_pkg.sv
// constants for the serial clock divider and data port
// assumes a byte-wide special-register port and one link clock pin
// What this block does
// - master clock is system clock over 2*(div+1)
// - data write fills buffer, starts master transfer
// - data read returns receive buffer, not transmit
// - polarity setting inverts serial clock everywhere
// - buffer-empty clears on write, sets on load or slave start
// - done flag set per transfer, software clears
// - master samples late, slave samples mid-bit
package spcd_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [7:0] SPCD_ADDR_CLK_DIV = 8'ha2;
   localparam logic [7:0] SPCD_ADDR_DATA = 8'ha3;
   localparam logic [7:0] SPCD_CLK_DIV_RST = 8'h00;
   localparam logic [7:0] SPCD_DATA_RST = 8'h00;
   // ----------------------------------------
   // sizes and counts
   // ----------------------------------------
   localparam int SPCD_BYTE_W = 8;
   localparam int SPCD_FIFO_DEPTH = 8;
   localparam logic [2:0] SPCD_LAST_BIT = 3'h7;
   typedef enum logic {SPCD_IDLE, SPCD_RUN} spcd_state_t;
endpackage : spcd_pkg

//--- test/spcd_peer.sv
// slave-side peer on the far end of master transfers
// assumes sck and mosi from the controller; miso goes to its sync input
`timescale 1ns/1ps
module spcd_peer (
   // serial pins
   input wire logic sck,
   input wire logic sck_oe_n,
   input wire logic pol,
   input wire logic mosi,
   output logic miso,
   // byte to send and byte seen
   input wire logic start,
   input wire logic [7:0] tx_byte,
   output logic [7:0] rx_byte
);
   int n = 8;
   wire s = sck ^ pol;
   initial miso = 1'b0;
   // ----------------------------------------
   // frame start, sample and shift edges
   // ----------------------------------------
   always @(posedge start) begin
      n = 0;
      rx_byte = 8'h00;
   end
   always @(posedge s) rx_byte = {rx_byte[6:0], mosi};
   always @(negedge s) n = n + 1;
   // released line shows the inverse of its last level
   always @(n or sck_oe_n or tx_byte) begin
      if (!sck_oe_n && n < 8) begin
         miso = tx_byte[7-n];
      end else begin
         miso = ~miso;
      end
   end
endmodule : spcd_peer

//--- test/spcd_top_tb.sv
// bench for divider, data port and receive fifo, master and slave
// assumes spcd_top and the peer model spcd_peer
`timescale 1ns/1ps
module spcd_top_tb;
   import spcd_pkg::*;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b0;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, p_tx, p_rx;
   logic sfr_wr, sfr_rd, master_en, pol, done_clear, txe, done, lk_sck, sck_o, sck_oe_n;
   logic mosi_i, mosi_o, mosi_oe_n, miso_i, miso_o, miso_oe_n, nss_n_i, p_start;
   int n_fail = 0;
   int samples_checked = 0;
   int exp_q[$];
   always #20 sys_clk = ~sys_clk;
   spcd_top i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .spi_en(1'b1),
      .master_en(master_en), .clock_polarity_select(pol), .clock_phase_select(1'b0),
      .done_clear(done_clear), .transmit_buffer_empty(txe), .transfer_done_flag(done),
      .lk_sck(lk_sck), .sck_o(sck_o), .sck_oe_n(sck_oe_n), .mosi_i(mosi_i), .mosi_o(mosi_o),
      .mosi_oe_n(mosi_oe_n), .miso_i(miso_i), .miso_o(miso_o), .miso_oe_n(miso_oe_n),
      .nss_n_i(nss_n_i));
   spcd_peer i_peer (.sck(sck_o), .sck_oe_n(sck_oe_n), .pol(pol), .mosi(mosi_o), .miso(miso_i),
      .start(p_start), .tx_byte(p_tx), .rx_byte(p_rx));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic close_out;
      $display("checks %0d failures %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : close_out
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge sys_clk);
      sfr_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge sys_clk);
      sfr_rd <= 1'b0;
      @(posedge sys_clk);
      d = sfr_rdata;
   endtask : rd
   task automatic wait_done(input int lim);
      int k = 0;
      while (done !== 1'b1 && k < lim) begin
         @(posedge sys_clk);
         k++;
      end
      if (k >= lim) begin
         n_fail++;
         close_out();
      end
   endtask : wait_done
   // counts cycles while sck_o stays at v
   task automatic span(input logic v, output int k);
      k = 0;
      while (sck_o === v && k < 600) begin
         @(posedge sys_clk);
         k++;
      end
      if (k >= 600) begin
         n_fail++;
         close_out();
      end
   endtask : span
   task automatic clr;
      done_clear <= 1'b1;
      @(posedge sys_clk);
      done_clear <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk("done cleared", 16'(done), 16'h0);
   endtask : clr
   // one master byte: divider, polarity, byte out, peer byte in
   task automatic xfer(input logic [7:0] dv, input logic pl, input logic [7:0] tx,
      input logic [7:0] sl);
      int k;
      pol <= pl;
      wr(SPCD_ADDR_CLK_DIV, dv);
      @(posedge sys_clk);
      p_tx <= sl;
      p_start <= 1'b1;
      @(posedge sys_clk);
      p_start <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk("sck idle", 16'(sck_o), 16'(pl));
      chk("sck drive", 16'(sck_oe_n), 16'h0);
      chk("mosi drive", 16'(mosi_oe_n), 16'h0);
      wr(SPCD_ADDR_DATA, tx);
      @(posedge sys_clk);
      chk("txe after write", 16'(txe), 16'h0);
      span(pl, k);
      span(~pl, k);
      chk("half period", 16'(k), 16'(dv) + 16'h1);
      chk("txe after load", 16'(txe), 16'h1);
      wait_done(4200);
      repeat (3) @(posedge sys_clk);
      chk("done sticky", 16'(done), 16'h1);
      clr();
      chk("peer got byte", 16'(p_rx), 16'(tx));
   endtask : xfer
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      logic [7:0] b, sb, mo;
      {sfr_addr, sfr_wdata, p_tx, sfr_wr, sfr_rd, done_clear, pol, mosi_i, p_start} = '0;
      master_en = 1'b1;
      lk_sck = 1'b0;
      nss_n_i = 1'b1;
      sys_rst <= 1'b1;
      void'($urandom(32'h2fc2d7e0));
      repeat (10) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      rd(SPCD_ADDR_CLK_DIV, b);
      chk("divider reset", 16'(b), 16'(SPCD_CLK_DIV_RST));
      rd(8'h55, b);
      chk("unmapped read", 16'(b), 16'h0);
      wr(SPCD_ADDR_CLK_DIV, 8'h5a);
      rd(SPCD_ADDR_CLK_DIV, b);
      chk("divider rw", 16'(b), 16'h5a);
      // divider zero: rate only, received byte dropped
      xfer(8'h00, 1'b0, 8'h3c, 8'hc3);
      rd(SPCD_ADDR_DATA, b);
      // fill the receive fifo
      for (int i = 0; i < 8; i++) begin
         b = (i == 0) ? 8'hff : 8'($urandom_range(9, 2));
         sb = 8'($urandom);
         exp_q.push_back(sb);
         xfer(b, 1'($urandom), 8'($urandom), sb);
      end
      // ninth byte stalls on a full fifo
      p_tx <= 8'h96;
      p_start <= 1'b1;
      @(posedge sys_clk);
      p_start <= 1'b0;
      wr(SPCD_ADDR_DATA, 8'h69);
      repeat (60) @(posedge sys_clk);
      chk("stalled done", 16'(done), 16'h0);
      for (int i = 0; i < 8; i++) begin
         rd(SPCD_ADDR_DATA, b);
         chk("rx byte", 16'(b), 16'(exp_q.pop_front()));
      end
      wait_done(4200);
      clr();
      rd(SPCD_ADDR_DATA, b);
      chk("late rx byte", 16'(b), 16'h96);
      // slave frame with inverted link clock
      master_en <= 1'b0;
      pol <= 1'b1;
      lk_sck <= 1'b1;
      @(posedge sys_clk);
      wr(SPCD_ADDR_DATA, 8'ha5);
      sb = 8'($urandom);
      nss_n_i <= 1'b0;
      #207;
      chk("miso drive", 16'(miso_oe_n), 16'h0);
      for (int i = 7; i >= 0; i--) begin
         mosi_i = sb[i];
         #80;
         mo[i] = miso_o;
         lk_sck = 1'b0;
         #80;
         lk_sck = 1'b1;
      end
      mosi_i = ~mosi_i;
      #200;
      nss_n_i = 1'b1;
      @(posedge sys_clk);
      wait_done(20);
      chk("slave out", 16'(mo), 16'ha5);
      rd(SPCD_ADDR_DATA, b);
      chk("slave in", 16'(b), 16'(sb));
      close_out();
   end
endmodule : spcd_top_tb
